//--- shared/mcd_consts.vh
// constants for the core datapath: alu operations, status bits, data map
// assumes plain verilog-2005 and inclusion by bare name
`ifndef MCD_CONSTS_VH
`define MCD_CONSTS_VH
`define MCD_IW 14
`define MCD_DW 8
`define MCD_PCW 13
`define MCD_STK_DEPTH 8
`define MCD_RAM_WORDS 256
`define MCD_RESET_PC 13'h0000
`define MCD_IRQ_VEC 13'h0004
// special function register addresses (low 7 bits, all banks)
`define MCD_A_INDF 7'h00
`define MCD_A_PCL 7'h02
`define MCD_A_STATUS 7'h03
`define MCD_A_FSR 7'h04
`define MCD_A_PCLATH 7'h0A
`define MCD_A_INTCON 7'h0B
// status bit positions
`define MCD_ST_C 0
`define MCD_ST_DC 1
`define MCD_ST_Z 2
`define MCD_ST_RP0 5
`define MCD_ST_RP1 6
`define MCD_ST_IRP 7
`define MCD_INTCON_GIE 7
// alu operations
`define MCD_ALU_PASS 4'h0
`define MCD_ALU_ADD 4'h1
`define MCD_ALU_SUB 4'h2
`define MCD_ALU_AND 4'h3
`define MCD_ALU_IOR 4'h4
`define MCD_ALU_XOR 4'h5
`define MCD_ALU_COM 4'h6
`define MCD_ALU_INC 4'h7
`define MCD_ALU_DEC 4'h8
`define MCD_ALU_RLF 4'h9
`define MCD_ALU_RRF 4'hA
`define MCD_ALU_SWAP 4'hB
`define MCD_ALU_CLR 4'hC
`define MCD_ALU_BCF 4'hD
`define MCD_ALU_BSF 4'hE
// timing: one instruction cycle at the documented core rate
`define MCD_ICYC_PS 166667
`define MCD_CLK_PS 40000
`endif

//--- hdl/mcd_alu.v
// 8-bit alu with carry, half-carry and zero outputs
// assumes operands are stable during a cycle; purely combinational
`include "mcd_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module mcd_alu #(
   parameter DW = `MCD_DW
) (
   // operands
   input wire [DW-1:0] opA,
   input wire [DW-1:0] opB,
   input wire carryIn,
   input wire [2:0] bitSel,
   input wire [3:0] aluOp,
   // result
   output reg [DW-1:0] result,
   output reg carryOut,
   output reg halfCarryOut,
   output wire zeroOut
);
   reg [DW:0] wide;
   reg [4:0] nib;
   reg [DW-1:0] mask;
   always @*
   begin
      wide = {1'b0, opA} + {1'b0, opB};
      nib = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
      mask = {{(DW-1){1'b0}}, 1'b1} << bitSel;
      result = opB;
      carryOut = carryIn;
      halfCarryOut = 1'b0;
      case (aluOp)
         `MCD_ALU_ADD:
         begin
            result = wide[DW-1:0];
            carryOut = wide[DW];
            halfCarryOut = nib[4];
         end
         `MCD_ALU_SUB:
         begin
            // b - a as b + ~a + 1; carry high means no borrow
            wide = {1'b0, opB} + {1'b0, ~opA} + {{DW{1'b0}}, 1'b1};
            nib = {1'b0, opB[3:0]} + {1'b0, ~opA[3:0]} + 5'h01;
            result = wide[DW-1:0];
            carryOut = wide[DW];
            halfCarryOut = nib[4];
         end
         `MCD_ALU_AND: result = opA & opB;
         `MCD_ALU_IOR: result = opA | opB;
         `MCD_ALU_XOR: result = opA ^ opB;
         `MCD_ALU_COM: result = ~opB;
         `MCD_ALU_INC: result = opB + {{(DW-1){1'b0}}, 1'b1};
         `MCD_ALU_DEC: result = opB - {{(DW-1){1'b0}}, 1'b1};
         `MCD_ALU_RLF:
         begin
            result = {opB[DW-2:0], carryIn};
            carryOut = opB[DW-1];
         end
         `MCD_ALU_RRF:
         begin
            result = {carryIn, opB[DW-1:1]};
            carryOut = opB[0];
         end
         `MCD_ALU_SWAP: result = {opB[3:0], opB[DW-1:4]};
         `MCD_ALU_CLR: result = {DW{1'b0}};
         `MCD_ALU_BCF: result = opB & ~mask;
         `MCD_ALU_BSF: result = opB | mask;
         default: result = opB;
      endcase
   end
   assign zeroOut = (result == {DW{1'b0}});
endmodule // mcd_alu
`default_nettype wire

//--- hdl/mcd_core.v
// core datapath: fetch/execute pipeline, decoder, register file, stack
// assumes synchronous program memory data valid one cycle after the address
`include "mcd_consts.vh"
`timescale 1ns/10ps
`default_nettype none
// How it works
// - one 14-bit word fetched per cycle on its own program bus
// - next word fetched while the current one executes
// - plain instructions take one cycle, branches two
// - decoder covers exactly 35 single-word instructions
// - 8-bit two's complement alu: add, subtract, shift, logic
// - operands from accumulator with file register or literal
// - accumulator has no data address, reached only implicitly
// - alu updates carry, half-carry and zero in status
// - on subtraction carry is inverted borrow, half-carry inverted nibble borrow
// - special registers including program counter live in data space, direct or indirect
// - any operation works on any register in any addressing mode
// - eight-level return stack, several interrupt sources accepted
// - 256 bytes of 8-bit general purpose ram
module mcd_core #(
   parameter IW = `MCD_IW,
   parameter DW = `MCD_DW,
   parameter PCW = `MCD_PCW,
   parameter STK = `MCD_STK_DEPTH,
   parameter RAMW = `MCD_RAM_WORDS,
   parameter NIRQ = 4
) (
   // clock and reset
   input wire core_clk,
   input wire srst,
   // program bus
   output reg [PCW-1:0] progAddr_q,
   input wire [IW-1:0] progData,
   // interrupt sources
   input wire [NIRQ-1:0] irqReq,
   // observation
   output reg [DW-1:0] accum_q,
   output reg [DW-1:0] status_q,
   output reg flushing_q,
   output reg stackOverflow_q
);
   localparam ICYC_CLKS = (`MCD_ICYC_PS + `MCD_CLK_PS - 1) / `MCD_CLK_PS;
   localparam S_RUN = 1'b0;
   localparam S_FLUSH = 1'b1;

   reg [DW-1:0] ram [0:RAMW-1];
   reg [PCW-1:0] stack [0:STK-1];
   reg [2:0] sp_q;
   reg [PCW-1:0] pc_q;
   reg [DW-1:0] fsr_q, pclath_q, intcon_q;
   reg state_q;
   reg [IW-1:0] ir;
   reg [DW-1:0] fileRd, opA, opB, wrVal, lit;
   reg [8:0] fAddr;
   reg [3:0] aluOp;
   reg toFile, toAcc, doFlags, useLit, branch, skip, push, pop, legal;
   reg [PCW-1:0] target;
   wire [DW-1:0] aluRes;
   wire aluC, aluDC, aluZ;
   wire irqPend = (|irqReq) && intcon_q[`MCD_INTCON_GIE];
   integer i;

   // register-file read, indirect through fsr when address is zero
   always @*
   begin
      ir = progData;
      lit = ir[DW-1:0];
      if (ir[6:0] == `MCD_A_INDF)
         fAddr = {status_q[`MCD_ST_IRP], fsr_q};
      else
         fAddr = {status_q[`MCD_ST_RP1:`MCD_ST_RP0], ir[6:0]};
      case (fAddr[6:0])
         `MCD_A_PCL: fileRd = pc_q[DW-1:0];
         `MCD_A_STATUS: fileRd = status_q;
         `MCD_A_FSR: fileRd = fsr_q;
         `MCD_A_PCLATH: fileRd = pclath_q;
         `MCD_A_INTCON: fileRd = intcon_q;
         `MCD_A_INDF: fileRd = {DW{1'b0}};
         default: fileRd = ram[fAddr[7:0]];
      endcase
   end

   // decoder for the 35 instructions
   always @*
   begin
      aluOp = `MCD_ALU_PASS;
      toFile = 1'b0;
      toAcc = 1'b0;
      doFlags = 1'b0;
      useLit = 1'b0;
      branch = 1'b0;
      skip = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      legal = 1'b1;
      target = {pclath_q[4:3], ir[10:0]};
      casez (ir[13:8])
         6'b00_0000:
         begin
            if (ir[7])
               toFile = 1'b1; // move accumulator to file
            else if (ir[6:0] == 7'h08 || ir[6:0] == 7'h09)
            begin
               branch = 1'b1; // return or return-from-interrupt
               pop = 1'b1;
            end
            else
               legal = (ir[6:0] == 7'h00 || ir[6:0] == 7'h64 || ir[6:0] == 7'h63);
         end
         6'b00_0001:
         begin
            aluOp = `MCD_ALU_CLR;
            toFile = ir[7];
            toAcc = !ir[7];
            doFlags = 1'b1;
         end
         6'b00_0010: aluOp = `MCD_ALU_SUB;
         6'b00_0011: aluOp = `MCD_ALU_DEC;
         6'b00_0100: aluOp = `MCD_ALU_IOR;
         6'b00_0101: aluOp = `MCD_ALU_AND;
         6'b00_0110: aluOp = `MCD_ALU_XOR;
         6'b00_0111: aluOp = `MCD_ALU_ADD;
         6'b00_1000: aluOp = `MCD_ALU_PASS;
         6'b00_1001: aluOp = `MCD_ALU_COM;
         6'b00_1010: aluOp = `MCD_ALU_INC;
         6'b00_1011: begin aluOp = `MCD_ALU_DEC; skip = 1'b1; end
         6'b00_1100: aluOp = `MCD_ALU_RRF;
         6'b00_1101: aluOp = `MCD_ALU_RLF;
         6'b00_1110: aluOp = `MCD_ALU_SWAP;
         6'b00_1111: begin aluOp = `MCD_ALU_INC; skip = 1'b1; end
         6'b01_00??: begin aluOp = `MCD_ALU_BCF; toFile = 1'b1; end
         6'b01_01??: begin aluOp = `MCD_ALU_BSF; toFile = 1'b1; end
         6'b01_1???: skip = 1'b1; // bit tests
         6'b10_0???: begin branch = 1'b1; push = 1'b1; end
         6'b10_1???: branch = 1'b1;
         6'b11_00??: begin toAcc = 1'b1; useLit = 1'b1; end
         6'b11_01??: begin branch = 1'b1; pop = 1'b1; toAcc = 1'b1; useLit = 1'b1; end
         6'b11_1000: begin aluOp = `MCD_ALU_IOR; useLit = 1'b1; end
         6'b11_1001: begin aluOp = `MCD_ALU_AND; useLit = 1'b1; end
         6'b11_1010: begin aluOp = `MCD_ALU_XOR; useLit = 1'b1; end
         6'b11_110?: begin aluOp = `MCD_ALU_SUB; useLit = 1'b1; end
         6'b11_111?: begin aluOp = `MCD_ALU_ADD; useLit = 1'b1; end
         default: legal = 1'b0;
      endcase
      if (ir[13:12] == 2'b00 && ir[11:8] >= 4'h2)
      begin
         toFile = ir[7];
         toAcc = !ir[7];
         doFlags = (aluOp != `MCD_ALU_SWAP) && !skip;
      end
      if (ir[13:11] == 3'b111)
      begin
         toAcc = 1'b1;
         doFlags = 1'b1;
      end
   end

   // operand selection: accumulator with file or literal
   always @*
   begin
      opA = accum_q;
      opB = useLit ? lit : fileRd;
      if (ir[13:12] == 2'b01)
         opB = fileRd;
      wrVal = (ir[13:8] == 6'h00 || ir[13:10] == 4'hC || ir[13:10] == 4'hD) ?
         (useLit ? lit : accum_q) : aluRes;
   end

   // shared alu, borrow polarity inverted on subtract
   mcd_alu #(
      .DW(DW)
   ) uAlu (
      .opA(opA),
      .opB(opB),
      .carryIn(status_q[`MCD_ST_C]),
      .bitSel(ir[9:7]),
      .aluOp(aluOp),
      .result(aluRes),
      .carryOut(aluC),
      .halfCarryOut(aluDC),
      .zeroOut(aluZ)
   );

   wire bitVal = fileRd[ir[9:7]];
   wire skipNow = skip && ((ir[13:12] == 2'b01) ? (bitVal == ir[10]) : aluZ);
   wire takeBr = (state_q == S_RUN) && legal && (branch || skipNow || irqPend);
   wire stackFull = (sp_q == STK[2:0] - 3'h1);

   always @(posedge core_clk)
   begin
      if (srst)
      begin
         pc_q <= `MCD_RESET_PC;
         progAddr_q <= `MCD_RESET_PC;
         accum_q <= {DW{1'b0}};
         status_q <= {DW{1'b0}};
         fsr_q <= {DW{1'b0}};
         pclath_q <= {DW{1'b0}};
         intcon_q <= {DW{1'b0}};
         sp_q <= 3'h0;
         state_q <= S_FLUSH;
         flushing_q <= 1'b1;
         stackOverflow_q <= 1'b0;
      end
      else if (state_q == S_FLUSH)
      begin
         // prefetched word discarded, no-op cycle
         state_q <= S_RUN;
         flushing_q <= 1'b0;
         pc_q <= progAddr_q + {{(PCW-1){1'b0}}, 1'b1};
         progAddr_q <= progAddr_q + {{(PCW-1){1'b0}}, 1'b1};
      end
      else
      begin
         if (irqPend)
         begin
            stack[sp_q] <= pc_q - {{(PCW-1){1'b0}}, 1'b1};
            sp_q <= sp_q + 3'h1;
            intcon_q[`MCD_INTCON_GIE] <= 1'b0;
            pc_q <= `MCD_IRQ_VEC;
            progAddr_q <= `MCD_IRQ_VEC;
         end
         else
         begin
            if (toAcc)
               accum_q <= wrVal;
            if (doFlags)
            begin
               status_q[`MCD_ST_Z] <= aluZ;
               if (aluOp == `MCD_ALU_ADD || aluOp == `MCD_ALU_SUB)
               begin
                  status_q[`MCD_ST_C] <= aluC;
                  status_q[`MCD_ST_DC] <= aluDC;
               end
               if (aluOp == `MCD_ALU_RLF || aluOp == `MCD_ALU_RRF)
                  status_q[`MCD_ST_C] <= aluC;
            end
            if (toFile)
            begin
               case (fAddr[6:0])
                  `MCD_A_STATUS: status_q <= wrVal;
                  `MCD_A_FSR: fsr_q <= wrVal;
                  `MCD_A_PCLATH: pclath_q <= wrVal;
                  `MCD_A_INTCON: intcon_q <= wrVal;
                  `MCD_A_INDF: ;
                  `MCD_A_PCL: ;
                  default: ram[fAddr[7:0]] <= wrVal;
               endcase
            end
            if (push)
            begin
               stack[sp_q] <= pc_q;
               sp_q <= sp_q + 3'h1;
               if (stackFull)
                  stackOverflow_q <= 1'b1;
            end
            if (pop)
            begin
               sp_q <= sp_q - 3'h1;
               if (ir[13:8] == 6'h00 && ir[0])
                  intcon_q[`MCD_INTCON_GIE] <= 1'b1;
            end
            if (toFile && fAddr[6:0] == `MCD_A_PCL)
            begin
               pc_q <= {pclath_q[4:0], wrVal};
               progAddr_q <= {pclath_q[4:0], wrVal};
            end
            else if (pop && branch)
            begin
               pc_q <= stack[sp_q - 3'h1];
               progAddr_q <= stack[sp_q - 3'h1];
            end
            else if (branch)
            begin
               pc_q <= target;
               progAddr_q <= target;
            end
            else if (skipNow)
            begin
               pc_q <= pc_q + {{(PCW-1){1'b0}}, 1'b1};
               progAddr_q <= pc_q + {{(PCW-1){1'b0}}, 1'b1};
            end
            else
            begin
               pc_q <= pc_q + {{(PCW-1){1'b0}}, 1'b1};
               progAddr_q <= pc_q + {{(PCW-1){1'b0}}, 1'b1};
            end
         end
         if (takeBr || (toFile && fAddr[6:0] == `MCD_A_PCL))
         begin
            state_q <= S_FLUSH;
            flushing_q <= 1'b1;
         end
      end
   end
endmodule // mcd_core
`default_nettype wire

//--- verif/mcd_core_checker.sv
// assertions on the core datapath ports
// assumes interrupts stay disabled and the upper pc latch stays zero
`timescale 1ns/10ps
`default_nettype none
module mcd_core_checker #(
   parameter IW = 14,
   parameter DW = 8,
   parameter PCW = 13,
   parameter NIRQ = 4
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // program bus
   input wire logic [PCW-1:0] progAddr_q,
   input wire logic [IW-1:0] progData,
   input wire logic [NIRQ-1:0] irqReq,
   // observation
   input wire logic [DW-1:0] accum_q,
   input wire logic [DW-1:0] status_q,
   input wire logic flushing_q,
   input wire logic stackOverflow_q
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (srst);
   wire logic run = !flushing_q;
   wire logic isLit = run && progData[13:12] == 2'b11 && progData[11:10] != 2'b01;
   wire logic isGoto = run && progData[13:11] == 3'b101;
   wire logic isMov = run && progData[13:10] == 4'b1100;
   wire logic isAdd = run && progData[13:9] == 5'b11111;
   wire logic isSub = run && progData[13:9] == 5'b11110;
   sequence s_flush_step;
      flushing_q ##1 !flushing_q;
   endsequence
   sequence s_next_word;
      !flushing_q && progAddr_q == $past(progAddr_q) + 1'b1;
   endsequence
   a_lit_straight: assert property (isLit |=> s_next_word)
      else $error("literal op did not advance by one word");
   a_goto_flush: assert property (isGoto |=> s_flush_step)
      else $error("branch without exactly one flush cycle");
   a_goto_target: assert property (isGoto |=> progAddr_q[10:0] == $past(progData[10:0]))
      else $error("branch went to wrong address");
   a_flush_step: assert property (flushing_q |=> progAddr_q == $past(progAddr_q) + 1'b1)
      else $error("flush cycle did not advance fetch address");
   a_load_lit: assert property (isMov |=> accum_q == $past(progData[7:0]))
      else $error("literal load wrong");
   a_add_carry: assert property (isAdd |=>
      {status_q[0], accum_q} == {1'b0, $past(accum_q)} + $past(progData[7:0]))
      else $error("add result or carry wrong");
   a_sub_borrow: assert property (isSub |=>
      status_q[1:0] == {$past(progData[3:0]) >= $past(accum_q[3:0]),
      $past(progData[7:0]) >= $past(accum_q)})
      else $error("subtract borrow flags wrong");
   a_zero_flag: assert property (isAdd || isSub |=> status_q[2] == (accum_q == 8'h00))
      else $error("zero flag wrong");
   a_ovf_sticky: assert property (stackOverflow_q |=> stackOverflow_q)
      else $error("overflow flag dropped");
endmodule // mcd_core_checker
bind mcd_core mcd_core_checker #(.IW(IW), .DW(DW), .PCW(PCW), .NIRQ(NIRQ)) u_chk (
   .core_clk(core_clk),
   .srst(srst),
   .progAddr_q(progAddr_q),
   .progData(progData),
   .irqReq(irqReq),
   .accum_q(accum_q),
   .status_q(status_q),
   .flushing_q(flushing_q),
   .stackOverflow_q(stackOverflow_q)
);
`default_nettype wire

//--- verif/mcd_core_datapath_tb_top.sv
// self-checking bench for the core datapath with a program memory model
// assumes registered program memory: word of the previous cycle's address
`timescale 1ns/10ps
`default_nettype none
module mcd_core_datapath_tb_top;
   // stimulus
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [13:0] progData = 14'h0000;
   logic [3:0] irqReq = 4'h0;
   // design outputs
   wire logic [12:0] progAddr_q;
   wire logic [7:0] accum_q;
   wire logic [7:0] status_q;
   wire logic flushing_q;
   wire logic stackOverflow_q;
   // bench state
   integer seed = 16;
   integer error_cnt = 0;
   integer n_checks = 0;
   integer i;
   integer depth = 0;
   logic [13:0] prog [0:255];
   logic [7:0] ram [0:255];
   logic [12:0] fetchAddr = 13'h0000;
   logic [12:0] pc = 13'h0000;
   logic [7:0] w = 8'h00;
   logic [2:0] fl = 3'h0;
   logic ovf = 1'b0;
   logic ran;
   logic [24:0] want;
   logic [24:0] notes [$];
   logic [13:0] base [0:10] = '{14'h3000, 14'h3E00, 14'h3C00, 14'h3900, 14'h3800,
      14'h3A00, 14'h0080, 14'h0800, 14'h0200, 14'h2800, 14'h2000};
   logic [11:0] steps [0:22] = '{12'h010, 12'h210, 12'h001, 12'h200, 12'h008, 12'h217,
      12'h0FF, 12'h101, 12'h00F, 12'h101, 12'h300, 12'h05A, 12'h630, 12'h030, 12'h604,
      12'h000, 12'h700, 12'h011, 12'h830, 12'h077, 12'h600, 12'h000, 12'h730};

   mcd_core u_dut (
      .core_clk(core_clk),
      .srst(srst),
      .progAddr_q(progAddr_q),
      .progData(progData),
      .irqReq(irqReq),
      .accum_q(accum_q),
      .status_q(status_q),
      .flushing_q(flushing_q),
      .stackOverflow_q(stackOverflow_q)
   );

   always #20 core_clk = ~core_clk;

   task check(input logic [24:0] seen, input logic [24:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp)
         begin
            error_cnt = error_cnt + 1;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask

   task conclude;
      begin
         $display("checks %0d errors %0d", n_checks, error_cnt);
         if (error_cnt == 0 && n_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask

   task sub(input logic [7:0] a);
      begin
         fl[1:0] = {a[3:0] >= w[3:0], a >= w};
         w = a - w;
      end
   endtask

   // lays one word into memory and notes its expected effect
   task op(input logic [3:0] code, input logic [7:0] k);
      logic [8:0] r;
      logic [7:0] f;
      logic jump;
      begin
         f = (k == 8'h00) ? ram[ram[8'h04]] : ram[k];
         jump = code > 4'h8;
         r = {1'b0, w} + k;
         case (code)
            4'h0: w = k;
            4'h1:
            begin
               fl[1:0] = {({1'b0, w[3:0]} + k[3:0]) > 5'h0F, r[8]};
               w = r[7:0];
            end
            4'h2: sub(k);
            4'h3: w = w & k;
            4'h4: w = w | k;
            4'h5: w = w ^ k;
            4'h6:
            begin
               if (k == 8'h00)
                  ram[ram[8'h04]] = w;
               else
                  ram[k] = w;
            end
            4'h7: w = f;
            4'h8: sub(f);
            4'hA:
            begin
               depth = depth + 1;
               if (depth == 8)
                  ovf = 1'b1;
            end
            default: ;
         endcase
         if (code != 4'h0 && code != 4'h6 && !jump)
            fl[2] = (w == 8'h00);
         prog[pc[7:0]] = base[code] | k;
         pc = jump ? {5'h00, k} : pc + 13'h0001;
         notes.push_back({jump ? pc : pc + 13'h0001, w, fl, ovf});
      end
   endtask

   // registered program memory and masked interrupt noise
   always @(posedge core_clk)
      fetchAddr <= progAddr_q;
   always @(negedge core_clk)
   begin
      progData <= prog[fetchAddr[7:0]];
      irqReq <= 4'($random(seed));
   end

   // result watcher: one note per executed word
   always @(posedge core_clk)
   begin
      ran = (srst === 1'b0) && (flushing_q === 1'b0);
      #1;
      if (ran && notes.size() != 0)
      begin
         want = notes.pop_front();
         check({progAddr_q, accum_q, status_q[2:0], stackOverflow_q}, want);
      end
   end

   initial
   begin
      for (i = 0; i < 256; i = i + 1)
      begin
         prog[i] = 14'h30EE;
         ram[i] = 8'h00;
      end
      // same jump at 0 and 1, whichever the flush skips
      op(4'h9, 8'h04);
      prog[1] = prog[0];
      for (i = 0; i < 23; i = i + 1)
         op(steps[i][11:8], steps[i][7:0]);
      for (i = 0; i < 40; i = i + 1)
         op(4'(($random(seed) & 32'h7FFF) % 6), 8'($random(seed)));
      op(4'h9, pc[7:0] + 8'h02);
      op(4'h9, pc[7:0] + 8'h03);
      for (i = 0; i < 8; i = i + 1)
         op(4'hA, pc[7:0] + 8'h01);
      op(4'h0, 8'h3C);
      repeat (5) @(negedge core_clk);
      check({progAddr_q, accum_q, status_q[2:0], flushing_q}, 25'h0000001);
      srst = 1'b0;
      for (i = 0; i < 3000 && notes.size() != 0; i = i + 1)
         @(negedge core_clk);
      if (notes.size() != 0)
         error_cnt = error_cnt + 1;
      conclude();
   end

   initial
   begin
      repeat (5000) @(posedge core_clk);
      error_cnt = error_cnt + 1;
      conclude();
   end
endmodule // mcd_core_datapath_tb_top
`default_nettype wire
